//--- src/gpfgh_top.sv
/*
 * gpfgh_top: three general purpose ports (two byte-wide, one of five pins plus an input-only pin) with direction bits,
 * output latches, sampled pin levels and peripheral overrides, reached over
 * an avalon-mm slave with waitrequest.
 * Assumes pin inputs synchronous to i_clk and peripheral controls driven by
 * on-chip units in the same clock domain.
 */
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - direction bit 1 turns the pin driver off, pin becomes input
// - direction bit 0 drives the pin from its output latch bit
// - third port is eight bidirectional pins, one direction bit each
// - latch register is mapped; reading it returns latch, not pins
// - every pin's direction is set independently of the others
// - after power-on reset all third port pins are digital inputs
// - external memory enable puts high address on four third port pins
// - external memory address outranks every other digital function there
// - compare/pwm output beats latch when direction 0; capture reads when 1
// - serial transmit or sync data output overrides latch on its pins
// - receive pin with direction 1 feeds the serial receive input
// - input-only pin is port input only while the fuse is clear
// - fuse set makes that pin the master clear input
// - input-only pin has no direction bit; that position not implemented
// - unimplemented bits read zero and ignore writes
// - first port analog pins come up analog; digital input then disabled
// - enabled comparator output overrides the first port latch data
module gpfgh_top
	import gpfgh_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [7:0]  i_pf_in,
	output logic      [7:0]  o_pf_out,
	output logic      [7:0]  o_pf_oe,
	input  wire logic [5:0]  i_pg_in,
	output logic      [4:0]  o_pg_out,
	output logic      [4:0]  o_pg_oe,
	input  wire logic [7:0]  i_ph_in,
	output logic      [7:0]  o_ph_out,
	output logic      [7:0]  o_ph_oe,
	input  wire logic [1:0]  i_cmp_oe,
	input  wire logic [1:0]  i_cmp_out,
	input  wire logic        i_ccp_out_en,
	input  wire logic        i_ccp_out,
	output logic             o_ccp_capture,
	input  wire logic        i_ser_tx_en,
	input  wire logic        i_ser_tx,
	input  wire logic        i_ser_dt_oe,
	input  wire logic        i_ser_dt,
	output logic             o_ser_rx,
	output logic             o_ser_ck_in,
	input  wire logic        i_emem_en,
	input  wire logic [3:0]  i_emem_addr,
	input  wire logic        i_reset_pin_fuse,
	output logic             o_master_clear_n
);

	logic [1:0]   rst_sync_q;
	logic         rst_n;
	gpfgh_state_t s_q;
	gpfgh_state_t s_d;
	logic         req;
	logic         acc_wr;
	logic [7:0]   wbyte;

	// returns true when the byte address hits one of the mapped registers
	function automatic logic gpfgh_mapped(input logic [5:0] a);
		case (a)
			GPFGH_F_PINS, GPFGH_F_LATCH, GPFGH_F_DIR, GPFGH_G_PINS, GPFGH_G_LATCH,
			GPFGH_G_DIR, GPFGH_H_PINS, GPFGH_H_LATCH, GPFGH_H_DIR,
			GPFGH_F_ANA: gpfgh_mapped = 1'b1;
			default:     gpfgh_mapped = 1'b0;
		endcase
	endfunction

	// reset released through two flops so every state flop leaves reset together
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// one wait cycle per access: data is captured first, answer next edge
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~s_q.ack;
	assign acc_wr            = i_avs_write & s_q.ack & i_avs_byteenable[0];
	assign wbyte             = i_avs_writedata[7:0];
	assign o_avs_readdata    = {24'h000000, s_q.rdata};

	// next state: sampling, read capture and register writes
	always_comb begin
		s_d       = s_q;
		s_d.ack   = req & ~s_q.ack;
		s_d.f_smp = i_pf_in;
		s_d.g_smp = i_pg_in;
		s_d.h_smp = i_ph_in;
		// read data settles in the wait cycle and stands at the answer edge
		if (i_avs_read && !s_q.ack) begin
			case (i_avs_address)
				GPFGH_F_PINS:  s_d.rdata = s_q.f_smp & ~{1'b0, s_q.f_ana};
				GPFGH_F_LATCH: s_d.rdata = s_q.f_lat;
				GPFGH_F_DIR:   s_d.rdata = s_q.f_dir;
				GPFGH_G_PINS:  s_d.rdata = {2'b00, s_q.g_smp[GPFGH_G_IN_ONLY] &
					~i_reset_pin_fuse, s_q.g_smp[4:0]};
				GPFGH_G_LATCH: s_d.rdata = {3'b000, s_q.g_lat};
				GPFGH_G_DIR:   s_d.rdata = {3'b000, s_q.g_dir};
				GPFGH_H_PINS:  s_d.rdata = s_q.h_smp;
				GPFGH_H_LATCH: s_d.rdata = s_q.h_lat;
				GPFGH_H_DIR:   s_d.rdata = s_q.h_dir;
				GPFGH_F_ANA:   s_d.rdata = {1'b0, s_q.f_ana};
				default:       s_d.rdata = 8'h00;
			endcase
		end
		// writes land on the answer edge; pin and latch addresses share a latch
		if (acc_wr && gpfgh_mapped(i_avs_address)) begin
			case (i_avs_address)
				GPFGH_F_PINS, GPFGH_F_LATCH: s_d.f_lat = wbyte;
				GPFGH_F_DIR:                 s_d.f_dir = wbyte;
				GPFGH_G_PINS, GPFGH_G_LATCH: s_d.g_lat = wbyte[4:0];
				GPFGH_G_DIR:                 s_d.g_dir = wbyte[4:0];
				GPFGH_H_PINS, GPFGH_H_LATCH: s_d.h_lat = wbyte;
				GPFGH_H_DIR:                 s_d.h_dir = wbyte;
				GPFGH_F_ANA:                 s_d.f_ana = wbyte[6:0];
				default:                     s_d.f_ana = s_q.f_ana;
			endcase
		end
	end

	// state register; ports come up as inputs with analog pins analog
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q       <= '0;
			s_q.f_dir <= GPFGH_DIR_RST;
			s_q.g_dir <= GPFGH_GDIR_RST;
			s_q.h_dir <= GPFGH_DIR_RST;
			s_q.f_ana <= GPFGH_ANA_RST;
			s_q.f_lat <= GPFGH_LATCH_RST;
			s_q.h_lat <= GPFGH_LATCH_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// first port: latch drives unless a comparator output claims the pin
	always_comb begin
		o_pf_oe  = ~s_q.f_dir;
		o_pf_out = s_q.f_lat;
		if (i_cmp_oe[1]) begin
			o_pf_out[GPFGH_F_CMP_TWO] = i_cmp_out[1];
		end
		if (i_cmp_oe[0]) begin
			o_pf_out[GPFGH_F_CMP_ONE] = i_cmp_out[0];
		end
	end

	// second port: peripherals outrank the latch; serial outputs force drive
	always_comb begin
		o_pg_oe  = ~s_q.g_dir;
		o_pg_out = s_q.g_lat;
		if (i_ccp_out_en) begin
			o_pg_out[GPFGH_G_CCP] = i_ccp_out;
		end
		if (i_ser_tx_en) begin
			o_pg_out[GPFGH_G_TX] = i_ser_tx;
			o_pg_oe[GPFGH_G_TX]  = 1'b1;
		end
		// the unit must see its own direction bit at 1 to receive
		if (i_ser_dt_oe) begin
			o_pg_out[GPFGH_G_RX] = i_ser_dt;
			o_pg_oe[GPFGH_G_RX]  = 1'b1;
		end
	end

	// peripheral input routing: only pins set as inputs feed the units
	assign o_ccp_capture    = s_q.g_dir[GPFGH_G_CCP] & i_pg_in[GPFGH_G_CCP];
	assign o_ser_rx         = s_q.g_dir[GPFGH_G_RX] & i_pg_in[GPFGH_G_RX];
	assign o_ser_ck_in      = s_q.g_dir[GPFGH_G_TX] & i_pg_in[GPFGH_G_TX];
	// master clear is active low; released whenever the fuse gives the pin away
	assign o_master_clear_n = ~i_reset_pin_fuse | i_pg_in[GPFGH_G_IN_ONLY];

	// third port: external memory address overrides data and direction
	for (genvar i = 0; i < 8; i++) begin : g_hpin
		if (i < GPFGH_EMEM_PINS) begin : g_emem
			assign o_ph_oe[i]  = i_emem_en | ~s_q.h_dir[i];
			assign o_ph_out[i] = i_emem_en ? i_emem_addr[i] : s_q.h_lat[i];
		end else begin : g_plain
			assign o_ph_oe[i]  = ~s_q.h_dir[i];
			assign o_ph_out[i] = s_q.h_lat[i];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	a_dir_floats:
	assert property (!i_emem_en && s_q.h_dir == 8'hFF |-> o_ph_oe == 8'h00)
		else $error("input pin still driven");

	a_latch_drives:
	assert property (!i_emem_en && !s_q.h_dir[7] |-> o_ph_oe[7] && o_ph_out[7] == s_q.h_lat[7])
		else $error("output pin not driven from latch");

	a_latch_readback:
	assert property (i_avs_read && i_avs_address == GPFGH_H_LATCH && !o_avs_waitrequest
		|-> o_avs_readdata[7:0] == s_q.h_lat)
		else $error("latch read returned wrong value");

	a_por_inputs:
	assert property ($rose(rst_sync_q[1]) |-> s_q.h_dir == GPFGH_DIR_RST && o_ph_oe == 8'h00
		|| i_emem_en)
		else $error("third port not input after reset");

	a_emem_override:
	assert property (i_emem_en |-> o_ph_oe[3:0] == 4'hF && o_ph_out[3:0] == i_emem_addr)
		else $error("address lines not on pins");

	a_ccp_priority:
	assert property (!s_q.g_dir[0] && i_ccp_out_en |-> o_pg_oe[0] && o_pg_out[0] == i_ccp_out)
		else $error("compare output lost to latch");

	a_tx_override:
	assert property (i_ser_tx_en |-> o_pg_oe[1] && o_pg_out[1] == i_ser_tx)
		else $error("serial transmit not on pin");

	a_rx_route:
	assert property (s_q.g_dir[2] |-> o_ser_rx == i_pg_in[2])
		else $error("receive pin not routed");

	a_unimpl_zero:
	assert property (i_avs_read && i_avs_address == GPFGH_G_DIR && !o_avs_waitrequest
		|-> o_avs_readdata[31:5] == 27'h0)
		else $error("unimplemented bits not zero");

	a_fuse_pin:
	assert property (i_avs_read && i_avs_address == GPFGH_G_PINS && !o_avs_waitrequest &&
		$past(i_reset_pin_fuse) |-> !o_avs_readdata[5])
		else $error("input-only pin read while master clear");

	a_write_latch:
	assert property (i_avs_write && i_avs_address == GPFGH_H_PINS && !o_avs_waitrequest &&
		i_avs_byteenable[0] |=> s_q.h_lat == $past(i_avs_writedata[7:0]))
		else $error("pin write did not reach latch");

	a_analog_mask:
	assert property (i_avs_read && i_avs_address == GPFGH_F_PINS && !o_avs_waitrequest &&
		$past(s_q.f_ana[0]) |-> !o_avs_readdata[0])
		else $error("analog pin read as digital");

	// first and second port drivers: pins without an override follow direction and latch
	a_f_input_float:
	assert property (s_q.f_dir[7] |-> !o_pf_oe[7])
		else $error("first port input pin driven");

	a_f_latch_drive:
	assert property (!s_q.f_dir[0] |-> o_pf_oe[0] && o_pf_out[0] == s_q.f_lat[0])
		else $error("first port pin not driven from latch");

	a_g_input_float:
	assert property (s_q.g_dir[3] |-> !o_pg_oe[3])
		else $error("second port input pin driven");

	a_g_latch_drive:
	assert property (!s_q.g_dir[4] |-> o_pg_oe[4] && o_pg_out[4] == s_q.g_lat[4])
		else $error("second port pin not driven from latch");

	// comparators only replace the value; every enable still follows its own bit
	a_f_dir_each:
	assert property (o_pf_oe == ~s_q.f_dir)
		else $error("first port enable not per direction bit");

	a_cmp_two_wins:
	assert property (i_cmp_oe[1] |-> o_pf_out[GPFGH_F_CMP_TWO] == i_cmp_out[1])
		else $error("comparator two lost to latch");

	a_cmp_one_wins:
	assert property (i_cmp_oe[0] |-> o_pf_out[GPFGH_F_CMP_ONE] == i_cmp_out[0])
		else $error("comparator one lost to latch");

	// second port peripheral paths
	a_capture_route:
	assert property (s_q.g_dir[GPFGH_G_CCP] |-> o_ccp_capture == i_pg_in[GPFGH_G_CCP])
		else $error("capture input not routed");

	a_dt_override:
	assert property (i_ser_dt_oe |-> o_pg_oe[GPFGH_G_RX] && o_pg_out[GPFGH_G_RX] == i_ser_dt)
		else $error("sync data not on pin");

	a_master_clear_input_follows:
	assert property (i_reset_pin_fuse |-> o_master_clear_n == i_pg_in[GPFGH_G_IN_ONLY])
		else $error("master clear not taken from pin");

	a_master_clear_input_idle:
	assert property (!i_reset_pin_fuse |-> o_master_clear_n)
		else $error("master clear asserted with fuse clear");

	// a read of the input-only pin with the fuse clear shows its sampled level
	a_g_pin_level:
	assert property (i_avs_read && i_avs_address == GPFGH_G_PINS && !o_avs_waitrequest &&
		!$past(i_reset_pin_fuse) |-> o_avs_readdata[5] == $past(s_q.g_smp[5]))
		else $error("input-only pin level lost");

	// address lines take only four pins; the upper half keeps its direction bits
	a_emem_upper:
	assert property (i_emem_en |-> o_ph_oe[7:4] == ~s_q.h_dir[7:4])
		else $error("address override spread past four pins");

	// register writes land on the answer edge and are seen one edge later
	a_g_dir_write:
	assert property (i_avs_write && i_avs_address == GPFGH_G_DIR && !o_avs_waitrequest &&
		i_avs_byteenable[0] |=> s_q.g_dir == $past(i_avs_writedata[4:0]))
		else $error("second port direction write lost");

	a_h_dir_write:
	assert property (i_avs_write && i_avs_address == GPFGH_H_DIR && !o_avs_waitrequest &&
		i_avs_byteenable[0] |=> s_q.h_dir == $past(i_avs_writedata[7:0]))
		else $error("third port direction write lost");

	// read data was captured one edge before the answer, so compare with that edge
	a_pins_read:
	assert property (i_avs_read && i_avs_address == GPFGH_H_PINS && !o_avs_waitrequest
		|-> o_avs_readdata[7:0] == $past(s_q.h_smp))
		else $error("pin read not the sampled level");

	a_f_latch_read:
	assert property (i_avs_read && i_avs_address == GPFGH_F_LATCH && !o_avs_waitrequest
		|-> o_avs_readdata[7:0] == s_q.f_lat)
		else $error("first latch read returned wrong value");

	a_upper_zero:
	assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");

	a_ana_por:
	assert property ($rose(rst_sync_q[1]) |-> s_q.f_ana == GPFGH_ANA_RST)
		else $error("analog pins not analog after reset");

endmodule

`default_nettype wire

//--- src/gpfgh_pkg.sv
/*
 * gpfgh_pkg: register map, reset values, field positions and state type of
 * the three-port general purpose i/o block.
 * Assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
 */
package gpfgh_pkg;

	// register byte offsets, one aligned word each
	localparam logic [5:0] GPFGH_F_PINS  = 6'h00;
	localparam logic [5:0] GPFGH_F_LATCH = 6'h04;
	localparam logic [5:0] GPFGH_F_DIR   = 6'h08;
	localparam logic [5:0] GPFGH_G_PINS  = 6'h0C;
	localparam logic [5:0] GPFGH_G_LATCH = 6'h10;
	localparam logic [5:0] GPFGH_G_DIR   = 6'h14;
	localparam logic [5:0] GPFGH_H_PINS  = 6'h18;
	localparam logic [5:0] GPFGH_H_LATCH = 6'h1C;
	localparam logic [5:0] GPFGH_H_DIR   = 6'h20;
	localparam logic [5:0] GPFGH_F_ANA   = 6'h24;

	// implemented widths
	localparam int GPFGH_G_WIDTH   = 5;
	localparam int GPFGH_ANA_WIDTH = 7;
	localparam int GPFGH_EMEM_PINS = 4;

	// field positions
	localparam int GPFGH_G_IN_ONLY = 5;
	localparam int GPFGH_G_CCP     = 0;
	localparam int GPFGH_G_TX      = 1;
	localparam int GPFGH_G_RX      = 2;
	localparam int GPFGH_F_CMP_TWO = 1;
	localparam int GPFGH_F_CMP_ONE = 2;

	// values after reset
	localparam logic [7:0] GPFGH_DIR_RST   = 8'hFF;
	localparam logic [4:0] GPFGH_GDIR_RST  = 5'h1F;
	localparam logic [7:0] GPFGH_LATCH_RST = 8'h00;
	localparam logic [6:0] GPFGH_ANA_RST   = 7'h7F;

	// everything the block stores
	typedef struct packed {
		logic [7:0] f_lat;
		logic [7:0] f_dir;
		logic [6:0] f_ana;
		logic [4:0] g_lat;
		logic [4:0] g_dir;
		logic [7:0] h_lat;
		logic [7:0] h_dir;
		logic [7:0] f_smp;
		logic [5:0] g_smp;
		logic [7:0] h_smp;
		logic       ack;
		logic [7:0] rdata;
	} gpfgh_state_t;

endpackage

//--- verification/gpfgh_board.sv
/*
 * gpfgh_board: board-side model of one byte-wide port.
 * Assumes the device enable is high while driving; undriven pins follow the
 * level the bench chooses for the outside world.
 */
`timescale 1ns/1ps
`default_nettype none
module gpfgh_board (
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_ext,
	output logic      [7:0] o_pin
);
	// driven bits show the device value, released bits the outside level
	assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule
`default_nettype wire

//--- verification/tb.sv
/*
 * tb: self-checking bench for gpfgh_top with three board models.
 * Assumes one 40 MHz clock and the package register map.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
	import gpfgh_pkg::*;
;
	logic        clk = 0, rst_n = 0, rd = 0, wr = 0, fuse = 0, emem = 0;
	logic        ccpe = 0, ccpo = 0, txe = 0, tx = 0, dte = 0, dt = 0;
	logic [5:0]  adr = '0;
	logic [31:0] wd = '0;
	logic [7:0]  rq, x, y, fe = '0, ge = '0, he = '0;
	logic [3:0]  ea = '0, be = 4'hF;
	logic [1:0]  cme = '0, cmo = '0;
	wire  [31:0] rdat;
	wire         wreq, cap, srx, sck, mcn;
	wire  [7:0]  pfo, pfe, pho, phe, pfp, pgp, php;
	wire  [4:0]  pgo, pge;
	int          err_total = 0, compares = 0;

	gpfgh_board bf (.i_out(pfo), .i_oe(pfe), .i_ext(fe), .o_pin(pfp));
	gpfgh_board bg (.i_out({3'h0, pgo}), .i_oe({3'h0, pge}), .i_ext(ge), .o_pin(pgp));
	gpfgh_board bh (.i_out(pho), .i_oe(phe), .i_ext(he), .o_pin(php));
	gpfgh_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_pf_in(pfp), .o_pf_out(pfo),
		.o_pf_oe(pfe), .i_pg_in(pgp[5:0]), .o_pg_out(pgo), .o_pg_oe(pge), .i_ph_in(php),
		.o_ph_out(pho), .o_ph_oe(phe), .i_cmp_oe(cme), .i_cmp_out(cmo),
		.i_ccp_out_en(ccpe), .i_ccp_out(ccpo), .o_ccp_capture(cap), .i_ser_tx_en(txe),
		.i_ser_tx(tx), .i_ser_dt_oe(dte), .i_ser_dt(dt), .o_ser_rx(srx), .o_ser_ck_in(sck),
		.i_emem_en(emem), .i_emem_addr(ea), .i_reset_pin_fuse(fuse),
		.o_master_clear_n(mcn));

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	// level a pin shows: driven bits from the latch, released bits from outside
	function automatic logic [7:0] pin_exp(input logic [7:0] lat, input logic [7:0] dir,
		input logic [7:0] ext);
		return (lat & ~dir) | (ext & dir);
	endfunction

	// one avalon transfer; held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		// read right after the edge, before the design's updates land
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				err_total++;
				test_done();
			end
		end while (wreq !== 1'b0);
		rq = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// let pin sampling and combinational paths settle
	task automatic st;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		forever #12.5 clk = ~clk;
	end

	initial begin
		x = 8'($urandom(25));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, GPFGH_H_DIR, 0);
		chk("h_dir", rq, GPFGH_DIR_RST);
		bus(0, GPFGH_G_DIR, 0);
		chk("g_dir", rq, 8'h1F);
		chk("h_oe", phe, 8'h00);
		$display("test reset done");
		// edge patterns first, then random mixes of inputs and outputs
		for (int i = 0; i < 8; i++) begin
			x = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			y = 8'($urandom);
			he <= 8'($urandom);
			bus(1, GPFGH_H_LATCH, y);
			bus(1, GPFGH_H_DIR, x);
			st();
			chk("h_oe", phe, ~x);
			chk("h_out", pho & ~x, y & ~x);
			bus(0, GPFGH_H_LATCH, 0);
			chk("h_lat", rq, y);
			bus(0, GPFGH_H_PINS, 0);
			chk("h_pins", rq, pin_exp(y, x, he));
		end
		bus(1, GPFGH_H_PINS, 8'hA5);
		bus(0, GPFGH_H_LATCH, 0);
		chk("h_lat", rq, 8'hA5);
		// a write without its low byte enabled must leave the latch alone
		be <= 4'hE;
		bus(1, GPFGH_H_LATCH, 8'h5A);
		be <= 4'hF;
		bus(0, GPFGH_H_LATCH, 0);
		chk("h_lat_be", rq, 8'hA5);
		$display("test third port done");
		bus(1, GPFGH_G_DIR, 8'hFF);
		bus(0, GPFGH_G_DIR, 0);
		chk("g_dir", rq, 8'h1F);
		bus(1, 6'h28, 8'hFF);
		bus(0, 6'h28, 0);
		chk("unmapped", rq, 8'h00);
		ge <= 8'($urandom);
		st();
		bus(0, GPFGH_G_PINS, 0);
		chk("g_pins", rq, ge & 8'h3F);
		chk("master_clear_input", {7'h0, mcn}, 8'h01);
		fuse <= 1'b1;
		st();
		bus(0, GPFGH_G_PINS, 0);
		chk("g_pins", rq, ge & 8'h1F);
		chk("master_clear_input", {7'h0, mcn}, {7'h0, ge[5]});
		chk("capture", {7'h0, cap}, {7'h0, ge[0]});
		chk("rx", {6'h0, sck, srx}, {6'h0, ge[1], ge[2]});
		ccpe <= 1'b1;
		ccpo <= 1'b1;
		txe <= 1'b1;
		dte <= 1'b1;
		dt <= 1'b1;
		bus(1, GPFGH_G_LATCH, 8'h00);
		bus(1, GPFGH_G_DIR, 8'h1E);
		st();
		chk("g_oe", {3'h0, pge}, 8'h07);
		chk("g_out", {3'h0, pgo}, 8'h05);
		$display("test second port done");
		bus(0, GPFGH_F_ANA, 0);
		chk("f_ana", rq, 8'h7F);
		fe <= 8'($urandom);
		st();
		bus(0, GPFGH_F_PINS, 0);
		chk("f_pins", rq, fe & 8'h80);
		bus(1, GPFGH_F_ANA, 0);
		st();
		bus(0, GPFGH_F_PINS, 0);
		chk("f_pins", rq, fe);
		cme <= 2'b11;
		cmo <= 2'b01;
		bus(1, GPFGH_F_DIR, 8'h00);
		st();
		chk("f_oe", pfe, 8'hFF);
		chk("f_cmp", pfo, 8'h04);
		$display("test first port done");
		bus(1, GPFGH_H_LATCH, 8'hFF);
		// low pins set as inputs so the address lines must override direction
		bus(1, GPFGH_H_DIR, 8'h0F);
		emem <= 1'b1;
		ea <= 4'hA;
		st();
		chk("emem_oe", phe, 8'hFF);
		chk("emem_out", pho, 8'hFA);
		$display("test external memory done");
		test_done();
	end
endmodule
`default_nettype wire
